// [design/tpr_device.sv]
/*
 * Device end: test reset handling, mode latch, test access port with
 * identification and bypass, and an Avalon-MM slave for the id word.
 * Assumes the pins arrive asynchronously and the test clock is slower
 * than a quarter of clock_i.
 */
// The Avalon-MM interface to the registers is this design's own decision.
`include "tpr_params.svh"

// Operation
// (R1) Board asserts both resets at power up
// (R2) Controller keeps test clock running during reset
// (R3) Core runs once system reset releases
// (R4) Test reset holds port and emulation logic
// (R5) Variant valid only after system reset
// (R6) Other instructions ignore system reset state
// (R7) Undriven test reset reads as asserted
// (R8) Passive controller pulses reset before use
// (R9) Mode pins latched on test reset rise; code latches only while system reset is released
// (R10) Latched pair selects scan or emulation
// (R11) Read-only id register in memory map
// (R12) Id register returns 32-bit code
// (R13) Variant 31:28, part number 27:12
// (R14) Manufacturer 11:1, bit zero one
// (R15) Asserted test reset forces reset state
module tpr_device (
  input wire logic clock_i,
  input wire logic rst_i,
  tpr_if.dev pins,
  input wire logic [31:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic core_reset_o,
  output logic emu_reset_o,
  output logic scan_mode_o,
  output logic mode_latched_o
);
  // ==========================================================
  // Pin synchronisation
  logic tck_s, tms_s, tdi_s, trst_n_s, sys_rst_n_s, mhi_s, mlo_s;

  tpr_sync #(.W(7)) u_sync (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .async_i({pins.tck, pins.tms, pins.tdi, pins.trst_n, pins.sys_rst_n,
              pins.mode_select_high, pins.mode_select_low}),
    .sync_o({tck_s, tms_s, tdi_s, trst_n_s, sys_rst_n_s, mhi_s, mlo_s})
  );

  logic tck_prev_q, trst_prev_q;
  logic tck_rise, tck_fall, trst_rise;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      tck_prev_q <= 1'b0;
      trst_prev_q <= 1'b0;
    end else begin
      tck_prev_q <= tck_s;
      trst_prev_q <= trst_n_s;
    end
  end

  assign tck_rise = tck_s & ~tck_prev_q;
  assign tck_fall = ~tck_s & tck_prev_q;
  assign trst_rise = trst_n_s & ~trst_prev_q;

  // ==========================================================
  // Reset outputs
  // Core reset follows only the system reset pin
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      core_reset_o <= 1'b1;
      emu_reset_o <= 1'b1;
    end else begin
      core_reset_o <= ~sys_rst_n_s; // (R3)
      emu_reset_o <= ~trst_n_s; // (R4) (R7)
    end
  end

  // ==========================================================
  // Mode latch
  logic [1:0] mode_q;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      mode_q <= `TPR_MODE_SCAN;
      mode_latched_o <= 1'b0;
    end else if (trst_rise && sys_rst_n_s) begin
      mode_q <= {mhi_s, mlo_s}; // (R9)
      mode_latched_o <= 1'b1;
    end
  end

  assign scan_mode_o = (mode_q == `TPR_MODE_SCAN); // (R10)

  // ==========================================================
  // Identification word
  tpr_pkg::tpr_word_t id_word;

  // Variant is only trusted once the core is out of reset
  assign id_word = {sys_rst_n_s ? `TPR_ID_VARIANT : `TPR_ID_VARIANT_UNSURE,
                    `TPR_ID_PART, `TPR_ID_MANUF, `TPR_ID_LSB}; // (R5) (R12) (R13) (R14)

  // ==========================================================
  // Test access port state machine
  tpr_pkg::tpr_tap_e tap_q, tap_d;

  always_comb begin
    tap_d = tap_q;
    unique case (tap_q)
      tpr_pkg::TAP_RESET: tap_d = tms_s ? tpr_pkg::TAP_RESET : tpr_pkg::TAP_IDLE;
      tpr_pkg::TAP_IDLE: tap_d = tms_s ? tpr_pkg::TAP_SEL_DR : tpr_pkg::TAP_IDLE;
      tpr_pkg::TAP_SEL_DR: tap_d = tms_s ? tpr_pkg::TAP_SEL_IR : tpr_pkg::TAP_CAP_DR;
      tpr_pkg::TAP_CAP_DR: tap_d = tms_s ? tpr_pkg::TAP_EXIT1_DR : tpr_pkg::TAP_SHIFT_DR;
      tpr_pkg::TAP_SHIFT_DR: tap_d = tms_s ? tpr_pkg::TAP_EXIT1_DR : tpr_pkg::TAP_SHIFT_DR;
      tpr_pkg::TAP_EXIT1_DR: tap_d = tms_s ? tpr_pkg::TAP_UPD_DR : tpr_pkg::TAP_PAUSE_DR;
      tpr_pkg::TAP_PAUSE_DR: tap_d = tms_s ? tpr_pkg::TAP_EXIT2_DR : tpr_pkg::TAP_PAUSE_DR;
      tpr_pkg::TAP_EXIT2_DR: tap_d = tms_s ? tpr_pkg::TAP_UPD_DR : tpr_pkg::TAP_SHIFT_DR;
      tpr_pkg::TAP_UPD_DR: tap_d = tms_s ? tpr_pkg::TAP_SEL_DR : tpr_pkg::TAP_IDLE;
      tpr_pkg::TAP_SEL_IR: tap_d = tms_s ? tpr_pkg::TAP_RESET : tpr_pkg::TAP_CAP_IR;
      tpr_pkg::TAP_CAP_IR: tap_d = tms_s ? tpr_pkg::TAP_EXIT1_IR : tpr_pkg::TAP_SHIFT_IR;
      tpr_pkg::TAP_SHIFT_IR: tap_d = tms_s ? tpr_pkg::TAP_EXIT1_IR : tpr_pkg::TAP_SHIFT_IR;
      tpr_pkg::TAP_EXIT1_IR: tap_d = tms_s ? tpr_pkg::TAP_UPD_IR : tpr_pkg::TAP_PAUSE_IR;
      tpr_pkg::TAP_PAUSE_IR: tap_d = tms_s ? tpr_pkg::TAP_EXIT2_IR : tpr_pkg::TAP_PAUSE_IR;
      tpr_pkg::TAP_EXIT2_IR: tap_d = tms_s ? tpr_pkg::TAP_UPD_IR : tpr_pkg::TAP_SHIFT_IR;
      tpr_pkg::TAP_UPD_IR: tap_d = tms_s ? tpr_pkg::TAP_SEL_DR : tpr_pkg::TAP_IDLE;
    endcase
  end

  // Asserted test reset wins over any clock edge, every cycle
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      tap_q <= tpr_pkg::TAP_RESET;
    end else if (!trst_n_s) begin
      tap_q <= tpr_pkg::TAP_RESET; // (R15) (R4)
    end else if (tck_rise) begin
      tap_q <= tap_d;
    end
  end

  // ==========================================================
  // Instruction register
  logic [3:0] ir_sr_q, ir_q;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ir_sr_q <= `TPR_IR_CAPTURE;
      ir_q <= `TPR_IR_IDCODE;
    end else if (!trst_n_s || tap_q == tpr_pkg::TAP_RESET) begin
      ir_sr_q <= `TPR_IR_CAPTURE;
      ir_q <= `TPR_IR_IDCODE; // (R4)
    end else if (tck_rise) begin
      unique case (tap_q)
        tpr_pkg::TAP_CAP_IR: ir_sr_q <= `TPR_IR_CAPTURE;
        tpr_pkg::TAP_SHIFT_IR: ir_sr_q <= {tdi_s, ir_sr_q[3:1]};
        tpr_pkg::TAP_UPD_IR: ir_q <= ir_sr_q;
        default: ir_q <= ir_q;
      endcase
    end
  end

  // ==========================================================
  // Data register: identification or one-bit bypass
  tpr_pkg::tpr_word_t dr_q;
  logic use_id;

  // Every code but the id read behaves as bypass, reset state regardless
  assign use_id = (ir_q == `TPR_IR_IDCODE); // (R6)

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      dr_q <= '0;
    end else if (tck_rise) begin
      unique case (tap_q)
        tpr_pkg::TAP_CAP_DR: dr_q <= use_id ? id_word : '0;
        tpr_pkg::TAP_SHIFT_DR: dr_q <= use_id ? {tdi_s, dr_q[31:1]}
                                              : {31'h0, tdi_s};
        default: dr_q <= dr_q;
      endcase
    end
  end

  // ==========================================================
  // Test data out changes on the falling test clock
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      pins.tdo_out <= 1'b0;
      pins.tdo_oe_n <= 1'b1;
    end else if (!trst_n_s) begin
      pins.tdo_oe_n <= 1'b1; // (R4)
    end else if (tck_fall) begin
      pins.tdo_out <= (tap_q == tpr_pkg::TAP_SHIFT_IR) ? ir_sr_q[0] : dr_q[0];
      pins.tdo_oe_n <= ~(tap_q == tpr_pkg::TAP_SHIFT_IR ||
                         tap_q == tpr_pkg::TAP_SHIFT_DR);
    end
  end

  // ==========================================================
  // Avalon-MM slave, one wait state per access
  logic ack_q;
  logic req;

  assign req = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = req & ~ack_q;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  // Writes are accepted and dropped: nothing here is writable
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      avs_readdata_o <= '0;
    end else if (avs_read_i && !ack_q) begin
      unique case (avs_address_i)
        `TPR_DEV_ID_ADDR: avs_readdata_o <= id_word; // (R11) (R12)
        `TPR_DEV_STAT_ADDR: avs_readdata_o <= {27'h0, mode_latched_o,
                                              mode_q, emu_reset_o,
                                              core_reset_o};
        default: avs_readdata_o <= '0;
      endcase
    end
  end

  logic unused_wdata;
  assign unused_wdata = ^avs_writedata_i;
endmodule

// [design/tpr_host.sv]
/*
 * Controller end: drives resets, mode pins and a free-running test clock,
 * shifts up to 63 bits per command, reusing 32-bit patterns, all ordered over Avalon-MM.
 * Assumes the device answers test data within five system cycles of the
 * falling test clock.
 */
`include "tpr_params.svh"

module tpr_host (
  input wire logic clock_i,
  input wire logic rst_i,
  tpr_if.host pins,
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o
);
  // ==========================================================
  // Registers
  logic [4:0] ctrl_q;
  tpr_pkg::tpr_word_t tms_q, tdi_q, tdo_cap_q;
  logic [5:0] len_q, idx_q;
  logic pending_q, active_q, ack_q, req, tdo_s;

  assign req = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = req & ~ack_q;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  // Reset state asserts both resets and drives test reset low.
  // Writes land at the edge where waitrequest is seen low, not before.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_q <= `TPR_CTRL_RESET; // (R1) (R8)
      tms_q <= '0;
      tdi_q <= '0;
      len_q <= '0;
    end else if (avs_write_i && ack_q && !pending_q && !active_q) begin
      unique case (avs_address_i)
        `TPR_HOST_CTRL: ctrl_q <= avs_writedata_i[4:0];
        `TPR_HOST_TMS: tms_q <= avs_writedata_i;
        `TPR_HOST_TDI: tdi_q <= avs_writedata_i;
        `TPR_HOST_CMD: len_q <= avs_writedata_i[5:0];
        default: len_q <= len_q;
      endcase
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      avs_readdata_o <= '0;
    end else if (avs_read_i && !ack_q) begin
      unique case (avs_address_i)
        `TPR_HOST_CTRL: avs_readdata_o <= {27'h0, ctrl_q};
        `TPR_HOST_TMS: avs_readdata_o <= tms_q;
        `TPR_HOST_TDI: avs_readdata_o <= tdi_q;
        `TPR_HOST_CMD: avs_readdata_o <= {31'h0, pending_q | active_q};
        `TPR_HOST_TDO: avs_readdata_o <= tdo_cap_q;
        default: avs_readdata_o <= '0;
      endcase
    end
  end

  // ==========================================================
  // Test clock divider, never stopped
  logic [3:0] cnt_q;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= '0;
      pins.tck <= 1'b0;
    end else begin
      cnt_q <= cnt_q + 4'h1;
      if (cnt_q == `TPR_TCK_RISE) begin
        pins.tck <= 1'b1; // (R2)
      end else if (cnt_q == `TPR_TCK_FALL) begin
        pins.tck <= 1'b0;
      end
    end
  end

  tpr_sync #(.W(1)) u_sync (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .async_i(pins.tdo),
    .sync_o(tdo_s)
  );

  // ==========================================================
  // Shift engine: drive on falling clock, sample just before rising
  logic cmd_wr;

  assign cmd_wr = avs_write_i && ack_q && !pending_q && !active_q &&
                  avs_address_i == `TPR_HOST_CMD &&
                  avs_writedata_i[5:0] != 6'h0;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      pending_q <= 1'b0;
      active_q <= 1'b0;
      idx_q <= '0;
      tdo_cap_q <= '0;
      pins.tms <= 1'b1;
      pins.tdi <= 1'b0;
    end else if (cmd_wr) begin
      pending_q <= 1'b1;
      idx_q <= '0;
      tdo_cap_q <= '0;
    end else if (cnt_q == `TPR_TCK_FALL && (pending_q || active_q)) begin
      pending_q <= 1'b0;
      active_q <= 1'b1;
      pins.tms <= tms_q[idx_q[4:0]];
      pins.tdi <= tdi_q[idx_q[4:0]];
    end else if (cnt_q == `TPR_TCK_SAMPLE && active_q) begin
      tdo_cap_q[idx_q[4:0]] <= tdo_s;
      idx_q <= idx_q + 6'h1;
      active_q <= (idx_q + 6'h1 != len_q);
    end
  end

  // ==========================================================
  // Reset and mode pins straight from control flops
  assign pins.sys_rst_n = ~ctrl_q[`TPR_CTRL_SYSRST];
  assign pins.trst_oe_n = ~ctrl_q[`TPR_CTRL_TRST_DRV];
  assign pins.trst_out = ctrl_q[`TPR_CTRL_TRST_LVL]; // (R8) (R9)
  assign pins.mode_select_low = ctrl_q[`TPR_CTRL_MODE_LO];
  assign pins.mode_select_high = ctrl_q[`TPR_CTRL_MODE_HI];
endmodule

// [design/tpr_if.sv]
/*
 * Pin-level carrier between the scan controller and the device.
 * Assumes the bench instantiates it once and connects both ends.
 */
interface tpr_if;
  logic tck;
  logic tms;
  logic tdi;
  logic trst_out;
  logic trst_oe_n;
  logic trst_n;
  logic tdo_out;
  logic tdo_oe_n;
  logic tdo;
  logic sys_rst_n;
  logic mode_select_high;
  logic mode_select_low;

  // ==========================================================
  // Wire resolution
  // Internal pulldown: an undriven test reset reads as asserted
  assign trst_n = trst_oe_n ? 1'b0 : trst_out; // (R7)
  assign tdo = tdo_oe_n ? 1'b1 : tdo_out;

  modport dev (
    input tck, tms, tdi, trst_n, sys_rst_n, mode_select_high,
    mode_select_low,
    output tdo_out, tdo_oe_n
  );

  modport host (
    output tck, tms, tdi, trst_out, trst_oe_n, sys_rst_n, mode_select_high,
    mode_select_low,
    input tdo
  );
endinterface

// [design/tpr_params.svh]
/*
 * Constants for the test port reset, mode latch and identification block.
 * Assumes inclusion by bare name from every design file that needs them.
 */
`ifndef TPR_PARAMS_SVH
`define TPR_PARAMS_SVH

// ==========================================================
// Identification word (values arbitrary, neutral)
`define TPR_ID_VARIANT 4'h3
`define TPR_ID_VARIANT_UNSURE 4'hf
`define TPR_ID_PART 16'h5a17
`define TPR_ID_MANUF 11'h2a5
`define TPR_ID_LSB 1'b1

// ==========================================================
// Device memory map (byte addresses)
`define TPR_DEV_ID_ADDR 32'h01b3f008
`define TPR_DEV_STAT_ADDR 32'h01b3f00c

// ==========================================================
// Instruction register
`define TPR_IR_IDCODE 4'h1
`define TPR_IR_BYPASS 4'hf
`define TPR_IR_CAPTURE 4'h1

// ==========================================================
// Mode pair codes
`define TPR_MODE_SCAN 2'h0

// ==========================================================
// Host register map and control bits
`define TPR_HOST_CTRL 5'h00
`define TPR_HOST_TMS 5'h04
`define TPR_HOST_TDI 5'h08
`define TPR_HOST_CMD 5'h0c
`define TPR_HOST_TDO 5'h10
`define TPR_CTRL_RESET 5'h03
`define TPR_CTRL_SYSRST 0
`define TPR_CTRL_TRST_DRV 1
`define TPR_CTRL_TRST_LVL 2
`define TPR_CTRL_MODE_LO 3
`define TPR_CTRL_MODE_HI 4

// ==========================================================
// Test clock divider: 16 system cycles per period
`define TPR_TCK_RISE 4'h7
`define TPR_TCK_FALL 4'hf
`define TPR_TCK_SAMPLE 4'h7

`endif

// [design/tpr_pkg.sv]
/*
 * Types shared by both ends of the test port.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package tpr_pkg;

  // ==========================================================
  // Test access port controller states
  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
    TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR,
    TAP_SHIFT_IR, TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
  } tpr_tap_e;

  typedef logic [31:0] tpr_word_t;

endpackage

// [design/tpr_sync.sv]
/*
 * Two-flop synchroniser for a bundle of independent levels.
 * Assumes each bit is a slow level; no multi-bit coherence is given.
 */
module tpr_sync #(
  parameter int W = 1
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      meta_q <= '0;
      sync_o <= '0;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule

// [verif/test_test_port_reset_mode_and_id.sv]
/*
 * Bench joining controller and device ends over the pin interface.
 * Assumes both Avalon slaves answer with waitrequest and constants
 * come from the shared header.
 */
`include "tpr_params.svh"

module test_test_port_reset_mode_and_id;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [31:0] ID_TRUE = {`TPR_ID_VARIANT, `TPR_ID_PART,
    `TPR_ID_MANUF, `TPR_ID_LSB};
  localparam logic [31:0] ID_RST = {`TPR_ID_VARIANT_UNSURE, `TPR_ID_PART,
    `TPR_ID_MANUF, `TPR_ID_LSB};

  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic [31:0] d_addr = 32'h0;
  logic [4:0] h_addr = 5'h0;
  logic d_rd = 1'b0, d_wr = 1'b0, h_rd = 1'b0, h_wr = 1'b0;
  logic [31:0] d_wd = 32'h0, h_wd = 32'h0, d_rdata, h_rdata, rv;
  logic d_wait, h_wait, core_rst, emu_rst, scan_m, latched;
  int n_fail = 0;
  int compares = 0;

  always #12.5 clock_i = ~clock_i;

  tpr_if pins();
  tpr_device tpr_device_inst (.clock_i(clock_i), .rst_i(rst_i), .pins(pins),
    .avs_address_i(d_addr), .avs_read_i(d_rd), .avs_write_i(d_wr),
    .avs_writedata_i(d_wd), .avs_readdata_o(d_rdata),
    .avs_waitrequest_o(d_wait), .core_reset_o(core_rst),
    .emu_reset_o(emu_rst), .scan_mode_o(scan_m), .mode_latched_o(latched));
  tpr_host tpr_host_inst (.clock_i(clock_i), .rst_i(rst_i), .pins(pins),
    .avs_address_i(h_addr), .avs_read_i(h_rd), .avs_write_i(h_wr),
    .avs_writedata_i(h_wd), .avs_readdata_o(h_rdata),
    .avs_waitrequest_o(h_wait));
  tpr_assertions tpr_assertions_inst (.clock_i(clock_i), .rst_i(rst_i),
    .tck(pins.tck), .tms(pins.tms), .tdi(pins.tdi),
    .trst_oe_n(pins.trst_oe_n), .trst_n(pins.trst_n),
    .tdo_out(pins.tdo_out), .tdo_oe_n(pins.tdo_oe_n), .tdo(pins.tdo),
    .sys_rst_n(pins.sys_rst_n));

  // ==========================================================
  // Bus and comparison helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // Request stands until waitrequest is seen low at a rising edge;
  // read data are taken at that same edge
  task automatic bus(input bit dv, input bit wr, input logic [31:0] a,
      input logic [31:0] wd);
    @(posedge clock_i);
    if (dv) begin
      d_addr <= a;
      d_rd <= !wr;
      d_wr <= wr;
      d_wd <= wd;
    end else begin
      h_addr <= a[4:0];
      h_rd <= !wr;
      h_wr <= wr;
      h_wd <= wd;
    end
    @(posedge clock_i);
    while ((dv ? d_wait : h_wait) !== 1'b0) begin
      @(posedge clock_i);
    end
    if (!wr) begin
      rv = dv ? d_rdata : h_rdata;
    end
    d_rd <= 1'b0;
    d_wr <= 1'b0;
    h_rd <= 1'b0;
    h_wr <= 1'b0;
  endtask

  task automatic ctrl(input logic [31:0] v);
    bus(0, 1, `TPR_HOST_CTRL, v);
    // Three edges of sync and register, plus margin
    repeat (5) @(posedge clock_i);
  endtask

  // Shift len bits, leaving the captured test data in rv
  task automatic shift(input logic [31:0] len, input logic [31:0] tms);
    int n;
    bus(0, 1, `TPR_HOST_TMS, tms);
    bus(0, 1, `TPR_HOST_TDI, 32'h0);
    bus(0, 1, `TPR_HOST_CMD, len);
    n = 0;
    rv = 32'h1;
    while (rv[0] !== 1'b0 && n < 300) begin
      bus(0, 0, `TPR_HOST_CMD, 32'h0);
      n++;
    end
    check(rv[0], 1'b0);
    bus(0, 0, `TPR_HOST_TDO, 32'h0);
  endtask

  // The test clock runs between commands, so each command ends parked in
  // a state that does not shift: capture and park in pause, shift bits
  // 28..0 and park again, then shift bits 31..29 and park in idle
  task automatic read_id();
    logic [28:0] lo;
    shift(5, 32'h0000000a);
    shift(32, 32'h40000001);
    lo = rv[30:2];
    shift(7, 32'h00000031);
    rv = {rv[4:2], lo};
  endtask

  // ==========================================================
  // Scenarios
  task automatic s_power_up();
    check(core_rst, 1'b1);
    check(emu_rst, 1'b1);
    check(latched, 1'b0);
    bus(1, 0, `TPR_DEV_STAT_ADDR, 32'h0);
    check(rv, 32'h3);
    bus(1, 0, `TPR_DEV_ID_ADDR, 32'h0);
    check(rv, ID_RST);
    ctrl(32'h01);
    check(pins.trst_oe_n, 1'b1);
    check(emu_rst, 1'b1);
  endtask

  task automatic s_sys_held();
    ctrl(32'h0f);
    check(emu_rst, 1'b0);
    check(latched, 1'b0);
    read_id();
    check(rv, ID_RST);
  endtask

  task automatic s_boot();
    ctrl(32'h02);
    check(core_rst, 1'b0);
    check(emu_rst, 1'b1);
    read_id();
    check(rv, 32'hffffffff);
    bus(1, 0, `TPR_DEV_ID_ADDR, 32'h0);
    check(rv, ID_TRUE);
    bus(1, 1, `TPR_DEV_ID_ADDR, 32'ha5a5a5a4);
    bus(1, 0, `TPR_DEV_ID_ADDR, 32'h0);
    check(rv, ID_TRUE);
    bus(1, 0, `TPR_DEV_ID_ADDR - 32'h4, 32'h0);
    check(rv, 32'h0);
  endtask

  // Ends on the scan pair so the last read runs in boundary-scan mode
  task automatic s_modes();
    for (int m = 3; m >= 0; m--) begin
      ctrl(32'h02 | (m << 3));
      ctrl(32'h06 | (m << 3));
      check(latched, 1'b1);
      check(scan_m, m == 0);
      bus(1, 0, `TPR_DEV_STAT_ADDR, 32'h0);
      check(rv, 32'h10 | (m << 2));
    end
    read_id();
    check(rv, ID_TRUE);
  endtask

  // ==========================================================
  // Sequence and verdict
  task automatic end_of_test();
    if (n_fail == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge clock_i);
    rst_i <= 1'b0;
    s_power_up();
    s_sys_held();
    s_boot();
    s_modes();
    end_of_test();
  end

  initial begin
    repeat (40000) @(posedge clock_i);
    n_fail++;
    end_of_test();
  end
endmodule

// [verif/tpr_assertions.sv]
/*
 * Checker for the pin-level link between controller and device.
 * Assumes it is instantiated beside the interface, fed its plain signals.
 */
module tpr_assertions (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic trst_oe_n,
  input wire logic trst_n,
  input wire logic tdo_out,
  input wire logic tdo_oe_n,
  input wire logic tdo,
  input wire logic sys_rst_n
);
  // ==========================================================
  // Assertions
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  a_reset_holds_tdo: assert property (!trst_n [*4] |-> tdo_oe_n)
    else $error("tdo still driven under test reset");
  a_pulldown_level: assert property (trst_oe_n |-> !trst_n)
    else $error("undriven test reset not low");
  a_tdo_idle_high: assert property (tdo_oe_n |-> tdo)
    else $error("released tdo not high");
  a_tdo_while_low: assert property
    (!tdo_oe_n && $changed(tdo_out) |-> !tck)
    else $error("tdo changed while test clock high");
  a_tck_high_width: assert property ($rose(tck) |-> tck [*8] ##1 !tck)
    else $error("test clock high phase not 8 cycles");
  a_tck_low_width: assert property ($fell(tck) |-> !tck [*8] ##1 tck)
    else $error("test clock low phase not 8 cycles");
  a_pins_on_fall: assert property
    ($changed(tms) || $changed(tdi) |-> $fell(tck))
    else $error("tms or tdi changed off the falling test clock");
  a_resets_at_start: assert property
    ($fell(rst_i) |-> !sys_rst_n && !trst_n && !trst_oe_n)
    else $error("both resets not asserted after power up");

  // ==========================================================
  // Coverage
  c_trst_rise: cover property ($rose(trst_n));
  c_tdo_driven: cover property (!tdo_oe_n);
  c_boot: cover property ($rose(sys_rst_n));
endmodule
